// ===== testbench/close_partner.sv
// user logic and breaker side model that raises and holds close requests
`timescale 1ns/100ps
`default_nettype none
module close_partner (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go_a,
    input wire logic go_m,
    input wire logic abort,
    input wire logic close_out,
    input wire logic refused,
    output logic auto_request,
    output logic manual_request
);
    // request held from start until the gate answers or the bench aborts
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            auto_request <= 1'b0;
            manual_request <= 1'b0;
        end
        else if (abort || close_out || refused)
        begin
            auto_request <= 1'b0;
            manual_request <= 1'b0;
        end
        else
        begin
            auto_request <= auto_request | go_a;
            manual_request <= manual_request | go_m;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/tb_sync_gate.sv
// self-checking bench for the synchro-check close gate
`timescale 1ns/100ps
`default_nettype none
module tb_sync_gate;
    // ----------
    // signals, clock and instances
    // ----------
    localparam int TICKS = 4;
    localparam logic [7:0] CTRL = sync_gate_pkg::CTRL_OFS;
    localparam logic [7:0] TIMING = sync_gate_pkg::TIMING_OFS;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, release_out, close_out, refused, e;
    logic cancel = 1'b0, block = 1'b0, bus_select = 1'b0, abort = 1'b0, vt_s = 1'b0;
    logic vt_l = 1'b0, vt_f = 1'b0, go_a = 1'b0, go_m = 1'b0, auto_request, manual_request;
    logic [7:0] tv [5][4] = '{'{8'h5a, 8'h00, 8'h02, 8'h01}, '{8'h59, 8'h00, 8'h00, 8'h00},
        '{8'h64, 8'h14, 8'h02, 8'h01}, '{8'h64, 8'h15, 8'h00, 8'h00},
        '{8'h64, 8'h00, 8'h03, 8'h00}};
    sync_gate_pkg::meas_s meas = '0;
    int err_total = 0, num_checks = 0, n;
    // free-running 50 MHz clock
    initial
    begin
        forever #10 pclk = ~pclk;
    end
    sync_gate #(.TICK_CYCLES(TICKS)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .auto_request(auto_request),
        .manual_request(manual_request), .cancel(cancel), .block(block),
        .bus_select(bus_select), .vt_block_line(vt_l), .vt_block_first(vt_f),
        .vt_block_second(vt_s), .meas(meas), .release_out(release_out),
        .close_out(close_out), .refused(refused));
    close_partner u_partner (.pclk(pclk), .presetn(presetn), .go_a(go_a), .go_m(go_m),
        .abort(abort), .close_out(close_out), .refused(refused),
        .auto_request(auto_request), .manual_request(manual_request));
    // ----------
    // shared tasks
    // ----------
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        begin
            num_checks++;
            if (seen !== exp)
            begin
                err_total++;
                $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task automatic tally_and_finish;
        begin
            $display("checks %0d mismatches %0d", num_checks, err_total);
            if (err_total == 0 && num_checks > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // apb transfer, waits for pready under a bound
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        begin
            @(posedge pclk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            k = 0;
            do
            begin
                @(posedge pclk);
                k++;
            end
            while (pready !== 1'b1 && k < 20);
            q = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            if (k >= 20)
                chk(32'h0, 32'h1);
        end
    endtask
    function automatic logic [31:0] ctrl(input logic [2:0] s, input logic [1:0] op,
        input logic sw, input logic [1:0] en);
        return {19'h0, 2'h1, en, 1'b0, sw, 2'h1, op, s};
    endfunction
    task automatic setm(input logic [7:0] lv, b1, b2, ang, slip);
        begin
            @(posedge pclk);
            for (int i = 0; i < 6; i++)
            begin
                meas.line[i] <= lv;
                meas.first_bus_section[i] <= b1;
                meas.second_bus_section[i] <= b2;
            end
            meas.angle_first <= ang;
            meas.angle_second <= ang;
            meas.slip_first <= slip;
            meas.slip_second <= slip;
        end
    endtask
    // one close request, answer checked, then back to idle
    task automatic run_req(input logic man, input logic ec, input logic er);
        begin
            @(posedge pclk);
            go_a <= ~man;
            go_m <= man;
            @(posedge pclk);
            go_a <= 1'b0;
            go_m <= 1'b0;
            n = 0;
            while (close_out !== 1'b1 && refused !== 1'b1 && n < 120)
            begin
                @(posedge pclk);
                n++;
            end
            chk({close_out, release_out, refused}, {ec, ec, er});
            abort <= 1'b1;
            repeat (3) @(posedge pclk);
            abort <= 1'b0;
            chk({close_out, release_out, refused}, 3'h0);
        end
    endtask
    task automatic fin(input string s);
        begin
            $display("test %s done", s);
        end
    endtask
    // ----------
    // test sequence
    // ----------
    initial
    begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CTRL, 32'h0);
        chk(q, 32'h0000_0ba8);
        apb(1'b0, sync_gate_pkg::LEVEL_OFS, 32'h0);
        chk(q, 32'h0000_1e46);
        apb(1'b0, sync_gate_pkg::AUTO_LIM_OFS, 32'h0);
        chk(q, 32'h1414_0a0a);
        apb(1'b0, sync_gate_pkg::MAN_LIM_OFS, 32'h0);
        chk(q, 32'h1414_0a0a);
        apb(1'b0, sync_gate_pkg::CHK_FREQ_OFS, 32'h0);
        chk(q, 32'h0000_0202);
        apb(1'b0, TIMING, 32'h0);
        chk(q, 32'h0032_2710);
        apb(1'b0, 8'h1c, 32'h0);
        chk({q, e}, {32'h0, 1'b1});
        fin("registers");
        apb(1'b1, TIMING, {16'h0032, 16'h0003});
        setm(8'h64, 8'h00, 8'h00, 8'h00, 8'h00);
        run_req(1'b0, 1'b1, 1'b0);
        setm(8'h46, 8'h1d, 8'h00, 8'h00, 8'h00);
        run_req(1'b0, 1'b1, 1'b0);
        setm(8'h45, 8'h00, 8'h00, 8'h00, 8'h00);
        run_req(1'b0, 1'b0, 1'b1);
        setm(8'h64, 8'h1e, 8'h00, 8'h00, 8'h00);
        run_req(1'b0, 1'b0, 1'b1);
        setm(8'h00, 8'h64, 8'h00, 8'h00, 8'h00);
        for (int m = 0; m < 4; m++)
        begin
            apb(1'b1, CTRL, ctrl(3'h0, 2'h1, 1'b0, 2'(m)));
            run_req(1'b0, m[1], ~m[1]);
        end
        setm(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
        run_req(1'b0, 1'b1, 1'b0);
        fin("energizing");
        apb(1'b1, CTRL, ctrl(3'h0, 2'h1, 1'b0, 2'h0));
        for (int i = 0; i < 5; i++)
        begin
            setm(8'h64, tv[i][0], tv[i][0], tv[i][1], tv[i][2]);
            run_req(1'b0, tv[i][3][0], ~tv[i][3][0]);
        end
        setm(8'h64, 8'h64, 8'h32, 8'h00, 8'h00);
        bus_select <= 1'b1;
        run_req(1'b0, 1'b0, 1'b1);
        bus_select <= 1'b0;
        run_req(1'b0, 1'b1, 1'b0);
        setm(8'h64, 8'h00, 8'h00, 8'h00, 8'h00);
        meas.first_bus_section[3] <= 8'h64;
        apb(1'b1, CTRL, ctrl(3'h3, 2'h1, 1'b0, 2'h0));
        run_req(1'b0, 1'b1, 1'b0);
        apb(1'b1, CTRL, ctrl(3'h0, 2'h1, 1'b0, 2'h0));
        run_req(1'b0, 1'b0, 1'b1);
        apb(1'b1, CTRL, ctrl(3'h7, 2'h1, 1'b0, 2'h0));
        run_req(1'b0, 1'b0, 1'b1);
        fin("synchro check");
        setm(8'h64, 8'h64, 8'h64, 8'h00, 8'h00);
        vt_l <= 1'b1;
        run_req(1'b0, 1'b0, 1'b1);
        vt_l <= 1'b0;
        vt_f <= 1'b1;
        run_req(1'b0, 1'b0, 1'b1);
        bus_select <= 1'b1;
        run_req(1'b0, 1'b1, 1'b0);
        vt_f <= 1'b0;
        vt_s <= 1'b1;
        run_req(1'b0, 1'b0, 1'b1);
        vt_s <= 1'b0;
        bus_select <= 1'b0;
        block <= 1'b1;
        run_req(1'b0, 1'b0, 1'b0);
        block <= 1'b0;
        apb(1'b1, sync_gate_pkg::MAN_LIM_OFS, 32'h1414_0a28);
        setm(8'h64, 8'h46, 8'h46, 8'h00, 8'h00);
        run_req(1'b0, 1'b0, 1'b1);
        run_req(1'b1, 1'b1, 1'b0);
        fin("plausibility, block, sources");
        setm(8'h00, 8'h00, 8'h00, 8'h5a, 8'h00);
        apb(1'b1, CTRL, ctrl(3'h0, 2'h0, 1'b0, 2'h0));
        run_req(1'b0, 1'b0, 1'b0);
        apb(1'b1, CTRL, ctrl(3'h0, 2'h2, 1'b0, 2'h0));
        run_req(1'b0, 1'b1, 1'b0);
        block <= 1'b1;
        run_req(1'b0, 1'b0, 1'b0);
        block <= 1'b0;
        fin("modes");
        apb(1'b1, CTRL, ctrl(3'h0, 2'h1, 1'b1, 2'h0));
        apb(1'b1, sync_gate_pkg::AUTO_LIM_OFS, 32'h6414_0a0a);
        apb(1'b1, TIMING, {16'h0032, 16'h000a});
        setm(8'h64, 8'h64, 8'h64, 8'h23, 8'h64);
        run_req(1'b0, 1'b1, 1'b0);
        setm(8'h64, 8'h64, 8'h64, 8'h28, 8'h64);
        run_req(1'b0, 1'b0, 1'b1);
        chk(n >= 10 * TICKS, 1'b1);
        run_req(1'b1, 1'b0, 1'b1);
        chk(n < 10, 1'b1);
        apb(1'b1, TIMING, {16'h0032, 16'h0032});
        go_a <= 1'b1;
        @(posedge pclk);
        go_a <= 1'b0;
        repeat (6) @(posedge pclk);
        apb(1'b0, sync_gate_pkg::STATUS_OFS, 32'h0);
        chk(q, 32'h0000_0003);
        // cancel while the request is held in switching: procedure must return to idle
        cancel <= 1'b1;
        apb(1'b0, sync_gate_pkg::STATUS_OFS, 32'h0);
        chk({q, close_out, refused}, 34'h0);
        abort <= 1'b1;
        @(posedge pclk);
        cancel <= 1'b0;
        abort <= 1'b0;
        fin("switching and cancel");
        tally_and_finish();
    end
    // watchdog against a hung handshake
    initial
    begin
        #400000;
        $display("unexpected at %0t: watchdog expired", $time);
        err_total++;
        tally_and_finish();
    end
endmodule
`default_nettype wire

// ===== verilog/sync_gate.sv
// synchro-check and synchro-switch close gate with apb settings
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module sync_gate #(
    parameter int TICK_CYCLES = sync_gate_pkg::TICK_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic auto_request,
    input wire logic manual_request,
    input wire logic cancel,
    input wire logic block,
    input wire logic bus_select,
    input wire logic vt_block_line,
    input wire logic vt_block_first,
    input wire logic vt_block_second,
    input wire sync_gate_pkg::meas_s meas,
    output logic release_out,
    output logic close_out,
    output logic refused
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] absdiff(input logic [7:0] a, input logic [7:0] b);
        absdiff = (a > b) ? a - b : b - a;
    endfunction

    // ----------------------------------------------------------------
    // apb register file
    // ----------------------------------------------------------------
    sync_gate_pkg::ctrl_s ctrl_r;
    logic [31:0] level_r;
    sync_gate_pkg::limits_s auto_lim_r;
    sync_gate_pkg::limits_s man_lim_r;
    logic [31:0] chk_freq_r;
    logic [31:0] timing_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    sync_gate_pkg::state_e state_r;
    sync_gate_pkg::state_e state_nxt;
    logic src_manual_r;
    logic release_r;
    logic close_r;
    logic refused_r;
    logic tick_r;
    logic [31:0] tick_cnt_r;
    logic [15:0] wait_ms_r;

    wire setup = psel && !penable;
    wire acc = psel && penable && pready_r;
    wire wr = acc && pwrite;
    wire hit_ctrl = paddr == sync_gate_pkg::CTRL_OFS;
    wire hit_level = paddr == sync_gate_pkg::LEVEL_OFS;
    wire hit_alim = paddr == sync_gate_pkg::AUTO_LIM_OFS;
    wire hit_mlim = paddr == sync_gate_pkg::MAN_LIM_OFS;
    wire hit_cfreq = paddr == sync_gate_pkg::CHK_FREQ_OFS;
    wire hit_timing = paddr == sync_gate_pkg::TIMING_OFS;
    wire hit_status = paddr == sync_gate_pkg::STATUS_OFS;
    wire mapped = hit_ctrl || hit_level || hit_alim || hit_mlim || hit_cfreq
        || hit_timing || hit_status;
    wire [31:0] status_w = {24'h0, src_manual_r, refused_r, close_r, release_r,
        1'b0, state_r};
    logic [31:0] rd_mux;

    // read data select
    always_comb
    begin
        if (hit_ctrl)
            rd_mux = ctrl_r;
        else if (hit_level)
            rd_mux = level_r;
        else if (hit_alim)
            rd_mux = auto_lim_r;
        else if (hit_mlim)
            rd_mux = man_lim_r;
        else if (hit_cfreq)
            rd_mux = chk_freq_r;
        else if (hit_timing)
            rd_mux = timing_r;
        else if (hit_status)
            rd_mux = status_w;
        else
            rd_mux = 32'h0;
    end

    // zero-wait access: ready in the first access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
        end
        else
        begin
            pready_r <= setup;
            pslverr_r <= setup && !mapped;
            prdata_r <= (setup && !pwrite) ? rd_mux : 32'h0;
        end
    end

    // settings, written in the access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_r <= sync_gate_pkg::CTRL_RST;
            level_r <= sync_gate_pkg::LEVEL_RST;
            auto_lim_r <= sync_gate_pkg::LIM_RST;
            man_lim_r <= sync_gate_pkg::LIM_RST;
            chk_freq_r <= sync_gate_pkg::CHK_FREQ_RST;
            timing_r <= sync_gate_pkg::TIMING_RST;
        end
        else if (wr)
        begin
            if (hit_ctrl)
                ctrl_r <= {19'h0, pwdata[12:0]};
            if (hit_level)
                level_r <= {16'h0, pwdata[15:0]};
            if (hit_alim)
                auto_lim_r <= pwdata;
            if (hit_mlim)
                man_lim_r <= pwdata;
            if (hit_cfreq)
                chk_freq_r <= {16'h0, pwdata[15:0]};
            if (hit_timing)
                timing_r <= pwdata;
        end
    end

    // ----------------------------------------------------------------
    // measurement selection and conditions
    // ----------------------------------------------------------------
    // active source: latched once a procedure runs
    wire src_man = (state_r == sync_gate_pkg::ST_IDLE) ? !auto_request : src_manual_r;
    wire [2:0] vsel = (ctrl_r.compared_voltage_select > 3'h5) ? 3'h0
        : ctrl_r.compared_voltage_select;
    wire [7:0] v_line = meas.line[vsel];
    wire [7:0] v_bus = bus_select ? meas.second_bus_section[vsel]
        : meas.first_bus_section[vsel];
    wire [7:0] angle = bus_select ? meas.angle_second : meas.angle_first;
    wire [7:0] slip = bus_select ? meas.slip_second : meas.slip_first;
    wire vt_ok = !vt_block_line
        && !(bus_select ? vt_block_second : vt_block_first);
    sync_gate_pkg::limits_s lim;
    assign lim = src_man ? man_lim_r : auto_lim_r;
    wire [7:0] chk_freq = src_man ? chk_freq_r[15:8] : chk_freq_r[7:0];
    sync_gate_pkg::op_mode_e op;
    assign op = src_man ? ctrl_r.manual_request_operation_mode
        : ctrl_r.auto_request_operation_mode;
    sync_gate_pkg::en_mode_e en;
    assign en = src_man ? ctrl_r.manual_energizing_mode
        : ctrl_r.auto_energizing_mode;
    wire sw_en = src_man ? ctrl_r.manual_sync_switching_enable
        : ctrl_r.auto_sync_switching_enable;

    // live and dead classification
    wire line_live = v_line >= level_r[7:0];
    wire bus_live = v_bus >= level_r[7:0];
    wire line_dead = v_line < level_r[15:8];
    wire bus_dead = v_bus < level_r[15:8];
    wire [7:0] vdiff = absdiff(v_line, v_bus);

    // energizing check per mode
    wire energ_ok = (en == sync_gate_pkg::EN_DBLL && bus_dead && line_live)
        || (en == sync_gate_pkg::EN_LBDL && bus_live && line_dead)
        || (en == sync_gate_pkg::EN_ANY && (bus_dead || line_dead));

    // synchro check: all three differences within limits
    wire chk_ok = line_live && bus_live && vdiff <= lim.check_voltage_diff_limit
        && slip <= chk_freq && angle <= lim.max_angle_diff;

    // advance angle = slip * 360 deg * breaker time
    wire [31:0] adv_full = 32'(slip) * 32'(timing_r[31:16]) * 32'd360 / 32'd100000;
    wire [7:0] adv_deg = (adv_full > 32'd180) ? 8'd180 : adv_full[7:0];
    wire sw_ok = line_live && bus_live && vdiff <= lim.switch_voltage_diff_limit
        && slip <= lim.sw_freq
        && absdiff(angle, adv_deg) <= lim.max_angle_diff;
    wire tmo_hit = wait_ms_r >= timing_r[15:0];
    wire req = auto_request || manual_request;
    wire abort = cancel || block;

    // ----------------------------------------------------------------
    // processing tick and wait timer
    // ----------------------------------------------------------------
    // one-cycle tick every millisecond, wait counted in ticks
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt_r <= 32'h0;
            tick_r <= 1'b0;
            wait_ms_r <= 16'h0;
        end
        else
        begin
            tick_r <= tick_cnt_r == 32'(TICK_CYCLES - 1);
            tick_cnt_r <= (tick_cnt_r == 32'(TICK_CYCLES - 1)) ? 32'h0 : tick_cnt_r + 32'h1;
            if (abort || state_r != sync_gate_pkg::ST_SWITCH)
                wait_ms_r <= 16'h0;
            else if (tick_r && !tmo_hit)
                wait_ms_r <= wait_ms_r + 16'h1;
        end
    end

    // ----------------------------------------------------------------
    // close procedure
    // ----------------------------------------------------------------
    // next state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            sync_gate_pkg::ST_IDLE:
                if (req && op != sync_gate_pkg::OP_OFF)
                    state_nxt = sync_gate_pkg::ST_EVAL;
            sync_gate_pkg::ST_EVAL:
                if (!req)
                    state_nxt = sync_gate_pkg::ST_IDLE;
                else if (op == sync_gate_pkg::OP_BYPASS)
                    state_nxt = sync_gate_pkg::ST_CLOSE;
                else if (op == sync_gate_pkg::OP_OFF)
                    state_nxt = sync_gate_pkg::ST_IDLE;
                else if (vt_ok && (energ_ok || chk_ok))
                    state_nxt = sync_gate_pkg::ST_CLOSE;
                else if (sw_en)
                    state_nxt = sync_gate_pkg::ST_SWITCH;
                else
                    state_nxt = sync_gate_pkg::ST_REFUSE;
            sync_gate_pkg::ST_SWITCH:
                if (!req)
                    state_nxt = sync_gate_pkg::ST_IDLE;
                else if (vt_ok && sw_ok)
                    state_nxt = sync_gate_pkg::ST_CLOSE;
                else if (tmo_hit)
                    state_nxt = sync_gate_pkg::ST_REFUSE;
            sync_gate_pkg::ST_CLOSE:
                if (!req)
                    state_nxt = sync_gate_pkg::ST_IDLE;
            sync_gate_pkg::ST_REFUSE:
                if (!req)
                    state_nxt = sync_gate_pkg::ST_IDLE;
            default:
                state_nxt = sync_gate_pkg::ST_IDLE;
        endcase
        if (abort)
            state_nxt = sync_gate_pkg::ST_IDLE;
    end

    // state and registered outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r <= sync_gate_pkg::ST_IDLE;
            src_manual_r <= 1'b0;
            release_r <= 1'b0;
            close_r <= 1'b0;
            refused_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            src_manual_r <= src_man;
            release_r <= state_nxt == sync_gate_pkg::ST_CLOSE;
            close_r <= state_nxt == sync_gate_pkg::ST_CLOSE;
            refused_r <= state_nxt == sync_gate_pkg::ST_REFUSE;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign release_out = release_r;
    assign close_out = close_r;
    assign refused = refused_r;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    block_gate_a: assert property (block |=> !close_r && !release_r)
        else $error("close or release while blocked");
    cancel_abort_a: assert property (cancel |=> state_r == sync_gate_pkg::ST_IDLE)
        else $error("cancel did not abort");
    timeout_refuse_a: assert property (state_r == sync_gate_pkg::ST_SWITCH && tmo_hit
        && req && !abort && !(vt_ok && sw_ok) |=> refused_r && !close_r)
        else $error("timeout did not refuse");
    bypass_pass_a: assert property (state_r == sync_gate_pkg::ST_EVAL && req
        && op == sync_gate_pkg::OP_BYPASS && !abort |=> close_r && release_r)
        else $error("bypass did not pass close");
    check_close_a: assert property (state_r == sync_gate_pkg::ST_EVAL && req
        && op == sync_gate_pkg::OP_ON && vt_ok && chk_ok && !abort |=> close_r)
        else $error("synchro check did not close");
    vt_plaus_a: assert property ($rose(close_r) && $past(op) != sync_gate_pkg::OP_BYPASS
        |-> $past(vt_ok))
        else $error("close with implausible voltage");
    tick_space_a: assert property (tick_r |=> !tick_r ##1 !tick_r)
        else $error("tick too frequent");
    timer_clear_a: assert property (state_r != sync_gate_pkg::ST_SWITCH |=> wait_ms_r == 16'h0)
        else $error("wait timer not cleared");
    off_mode_a: assert property (state_r == sync_gate_pkg::ST_IDLE
        && op == sync_gate_pkg::OP_OFF |=> state_r == sync_gate_pkg::ST_IDLE)
        else $error("off mode started procedure");
    close_hold_a: assert property (close_r && req && !abort |=> close_r)
        else $error("close dropped while requested");

    switch_close_c: cover property (state_r == sync_gate_pkg::ST_SWITCH ##1 close_r);
    refuse_c: cover property ($rose(refused_r));
    direct_close_c: cover property (state_r == sync_gate_pkg::ST_EVAL ##1 close_r);
    cancel_c: cover property (state_r == sync_gate_pkg::ST_SWITCH && cancel);
endmodule
`default_nettype wire

// ===== verilog/sync_gate_pkg.sv
// constants, types and register map of the synchro-check close gate
package sync_gate_pkg;
    // ----------------------------------------------------------------
    // clock and processing tick
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
    // ----------------------------------------------------------------
    // register offsets
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] LEVEL_OFS = 8'h04;
    localparam logic [7:0] AUTO_LIM_OFS = 8'h08;
    localparam logic [7:0] MAN_LIM_OFS = 8'h0c;
    localparam logic [7:0] CHK_FREQ_OFS = 8'h10;
    localparam logic [7:0] TIMING_OFS = 8'h14;
    localparam logic [7:0] STATUS_OFS = 8'h18;
    // ----------------------------------------------------------------
    // modes and states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {OP_OFF = 2'h0, OP_ON = 2'h1, OP_BYPASS = 2'h2} op_mode_e;
    typedef enum logic [1:0] {EN_OFF = 2'h0, EN_DBLL = 2'h1, EN_LBDL = 2'h2, EN_ANY = 2'h3} en_mode_e;
    typedef enum logic [2:0] {ST_IDLE = 3'h0, ST_EVAL = 3'h1, ST_SWITCH = 3'h3,
        ST_CLOSE = 3'h2, ST_REFUSE = 3'h6} state_e;
    // ----------------------------------------------------------------
    // register layouts
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [18:0] spare;
        en_mode_e manual_energizing_mode;
        en_mode_e auto_energizing_mode;
        logic manual_sync_switching_enable;
        logic auto_sync_switching_enable;
        op_mode_e manual_request_operation_mode;
        op_mode_e auto_request_operation_mode;
        logic [2:0] compared_voltage_select;
    } ctrl_s;
    typedef struct packed {
        logic [7:0] sw_freq;
        logic [7:0] max_angle_diff;
        logic [7:0] switch_voltage_diff_limit;
        logic [7:0] check_voltage_diff_limit;
    } limits_s;
    // measurements: magnitudes in % of rated, angle in deg, slip in 0.01 Hz
    typedef struct packed {
        logic [5:0][7:0] line;
        logic [5:0][7:0] first_bus_section;
        logic [5:0][7:0] second_bus_section;
        logic [7:0] angle_first;
        logic [7:0] angle_second;
        logic [7:0] slip_first;
        logic [7:0] slip_second;
    } meas_s;
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] CTRL_RST = 32'h0000_0ba8;
    localparam logic [31:0] LEVEL_RST = 32'h0000_1e46;
    localparam logic [31:0] LIM_RST = 32'h1414_0a0a;
    localparam logic [31:0] CHK_FREQ_RST = 32'h0000_0202;
    localparam logic [31:0] TIMING_RST = 32'h0032_2710;
endpackage
